// ### design/spl_pkg.sv
// Constants, register layout and state encodings of the serial port control block
//
// Notes on behaviour
// - Wait mode: port runs, events raise interrupt.
// - Halt freezes control; port stays inactive unless peripheral wake armed.
// - Peripheral halt wake only by transfer-done.
// - Several bytes during halt raise overrun.
// - Done while flag still set sets overrun.
// - Leaving peripheral role ends halt residue immediately.
// - Halt wake needs select low at entry.
// - One shared vector, enable and mask gated.
// - Enable bit 7 raises on done, fault or overrun flag.
// - Bit 6 connects pins; fault clears it.
// - Bit 4 selects controller role; fault clears.
// - Bit 3 sets serial clock idle level.
// - Bit 2 picks first or second edge.
// - Rate bits divide CPU clock 4..128.
// - Rate bits ignored in peripheral role.
// - Reset clears all eight control bits.
// - Byte end sets transfer-done flag, except the first after a peripheral wake.
// - Controller role with select low faults.
package spl_pkg;

  // ****************
  // Register offsets
  // ****************
  localparam logic [7:0] ADDR_DATA = 8'h21;
  localparam logic [7:0] ADDR_CTRL = 8'h22;
  localparam logic [7:0] ADDR_CSR = 8'h23;

  // ****************
  // Field positions
  // ****************
  localparam int CB_IE = 7;
  localparam int CB_PE = 6;
  localparam int CB_HALVE = 5;
  localparam int CB_ROLE = 4;
  localparam int CB_IDLE = 3;
  localparam int CB_CAPT = 2;
  localparam int CB_RATE1 = 1;
  localparam int CB_RATE0 = 0;

  // ****************
  // Reset values
  // ****************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ****************
  // Serial clock half periods in CPU cycles and last edge counts of a byte
  // ****************
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV32 = 7'h10;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [4:0] LAST_EDGE = 5'h0f;
  localparam logic [3:0] LAST_SAMPLE_PAIR = 4'h7;

  typedef enum logic [3:0] {
    SPL_RUN = 4'b0001,
    SPL_HALT_IDLE = 4'b0010,
    SPL_HALT_ARMED = 4'b0100,
    SPL_RESIDUE = 4'b1000
  } spl_pwr_e;

endpackage

// ### design/spl_clk_div.sv
// Serial clock divider producing one tick per half serial clock period
`timescale 1ns/10ps
`default_nettype none
module spl_clk_div
  import spl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] rate_sel,
  output logic tick
);

  logic [6:0] cnt;

  function automatic logic [6:0] half_of(input logic [2:0] s);
    case (s)
      3'b100: half_of = HALF_DIV4;
      3'b000: half_of = HALF_DIV8;
      3'b001: half_of = HALF_DIV16;
      3'b110: half_of = HALF_DIV32;
      3'b010: half_of = HALF_DIV64;
      3'b011: half_of = HALF_DIV128;
      default: half_of = HALF_DIV8;
    endcase
  endfunction

  // Restarts at every transfer so the first half period is whole
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt <= 7'h00;
      tick <= 1'b0;
    end else if (cnt == half_of(rate_sel) - 7'h01) begin
      cnt <= 7'h00;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 7'h01;
      tick <= 1'b0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_tick_spacing: assert property (tick |=> !tick)
    else $error("divider ticks on two adjacent cycles");
  a_fastest_rate: assert property (run && rate_sel == 3'b100 && tick ##1 run |=> tick)
    else $error("divide by four half period is not two cycles");

endmodule
`default_nettype wire

// ### design/spl_shifter.sv
// Byte shift engine for controller and peripheral roles
`timescale 1ns/10ps
`default_nettype none
module spl_shifter
  import spl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic ctrl,
  input wire logic idle_level_select,
  input wire logic capture_edge_select,
  input wire logic tick,
  input wire logic sel_low,
  input wire logic sck_in,
  input wire logic sd_in,
  input wire logic load,
  input wire logic [7:0] load_byte,
  output logic sck_lvl,
  output logic sd_out,
  output logic busy,
  output logic done,
  output logic [7:0] rx_byte
);

  logic [7:0] sr;
  logic [4:0] edges;
  logic sck_prev;
  logic edge_ev;
  logic lead;
  logic sample;
  logic last;

  always_comb begin
    if (ctrl) begin
      edge_ev = busy & tick;
      lead = (sck_lvl == idle_level_select);
    end else begin
      edge_ev = sel_low & (sck_in != sck_prev);
      lead = (sck_prev == idle_level_select);
    end
    sample = edge_ev & (lead ^ capture_edge_select);
    last = ctrl ? (edges == LAST_EDGE) : (sample && edges[4:1] == LAST_SAMPLE_PAIR);
  end

  assign rx_byte = sr;

  always_ff @(posedge clk) begin
    if (rst) begin
      sr <= BYTE_ZERO;
      edges <= 5'h00;
      sck_prev <= 1'b0;
      sck_lvl <= 1'b0;
      sd_out <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (en) begin
      done <= 1'b0;
      sck_prev <= sck_in;
      if (ctrl && !busy) begin
        sck_lvl <= idle_level_select;
      end
      if (!ctrl && !sel_low) begin
        edges <= 5'h00;
      end
      if (load && !busy) begin
        sr <= load_byte;
        sd_out <= load_byte[7];
        busy <= ctrl;
        edges <= 5'h00;
      end else if (edge_ev) begin
        edges <= last ? 5'h00 : edges + 5'h01;
        if (ctrl) begin
          sck_lvl <= ~sck_lvl;
        end
        if (sample) begin
          sr <= {sr[6:0], sd_in};
        end else begin
          sd_out <= sr[7];
        end
        if (last) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_idle_level: assert property (en && ctrl && !busy && !load ##1 en |-> sck_lvl == $past(idle_level_select))
    else $error("controller clock not at idle level between bytes");
  a_done_ends_busy: assert property (done |-> !busy)
    else $error("transfer marked done while still busy");

endmodule
`default_nettype wire

// ### design/spl_lowpower_irq_control.sv
// Serial port control, shared interrupt and low power handling
`timescale 1ns/10ps
`default_nettype none
module spl_lowpower_irq_control
  import spl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic cpu_irq_mask,
  input wire logic halt_mode,
  output logic irq,
  output logic halt_wake,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_n_in
);

  // ****************
  // Register state
  // ****************
  logic [7:0] serial_port_control;
  logic [7:0] data_buffer_reg;
  logic transfer_done_flag;
  logic overrun_flag;
  logic mode_fault_flag;
  logic wcol_flag;
  logic out_disable;
  logic select_source_choice;
  logic internal_select_level;
  logic done_armed;
  logic fault_armed;
  logic wcol_armed;
  spl_pwr_e pwr;
  spl_pwr_e next_pwr;

  // ****************
  // Decodes
  // ****************
  logic port_enable_bit;
  logic controller_role_bit;
  logic ss_eff_n;
  logic awake;
  logic wr_data;
  logic rd_data;
  logic wr_ctrl;
  logic rd_csr;
  logic wr_csr;
  logic clr_done;
  logic fault;
  logic count_done;
  logic take_byte;
  logic shift_en;
  logic div_run;
  logic div_tick;
  logic sh_sck;
  logic sh_sd;
  logic sh_busy;
  logic sh_done;
  logic [7:0] sh_rx;

  assign port_enable_bit = serial_port_control[CB_PE];
  assign controller_role_bit = serial_port_control[CB_ROLE];
  assign ss_eff_n = select_source_choice ? internal_select_level : ss_n_in;
  assign awake = (pwr == SPL_RUN) || (pwr == SPL_RESIDUE);
  assign wr_data = wr && awake && addr == ADDR_DATA;
  assign rd_data = rd && awake && addr == ADDR_DATA;
  assign wr_ctrl = wr && awake && addr == ADDR_CTRL;
  assign rd_csr = rd && awake && addr == ADDR_CSR;
  assign wr_csr = wr && awake && addr == ADDR_CSR;
  assign clr_done = done_armed && (rd_data || wr_data);
  assign fault = awake && port_enable_bit && controller_role_bit && !ss_eff_n;
  // The first byte completed after a peripheral wake only restores normal state
  assign count_done = sh_done && pwr != SPL_RESIDUE;
  assign take_byte = wr_data && (!transfer_done_flag || done_armed) && !sh_busy;
  // Halt freezes the engine unless a peripheral wake was armed
  assign shift_en = port_enable_bit && pwr != SPL_HALT_IDLE;
  assign div_run = shift_en && controller_role_bit && sh_busy;

  // ****************
  // Submodules
  // ****************
  spl_clk_div u_div (
    .clk(clk),
    .rst(rst),
    .run(div_run),
    .rate_sel({serial_port_control[CB_HALVE], serial_port_control[CB_RATE1],
               serial_port_control[CB_RATE0]}),
    .tick(div_tick)
  );

  spl_shifter u_shift (
    .clk(clk),
    .rst(rst),
    .en(shift_en),
    .ctrl(controller_role_bit),
    .idle_level_select(serial_port_control[CB_IDLE]),
    .capture_edge_select(serial_port_control[CB_CAPT]),
    .tick(div_tick),
    .sel_low(!ss_eff_n),
    .sck_in(sck_in),
    .sd_in(controller_role_bit ? miso_in : mosi_in),
    .load(take_byte),
    .load_byte(wdata),
    .sck_lvl(sh_sck),
    .sd_out(sh_sd),
    .busy(sh_busy),
    .done(sh_done),
    .rx_byte(sh_rx)
  );

  // ****************
  // Power state
  // ****************
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      SPL_RUN, SPL_RESIDUE: begin
        if (halt_mode) begin
          if (port_enable_bit && !controller_role_bit && !ss_eff_n) begin
            next_pwr = SPL_HALT_ARMED;
          end else begin
            next_pwr = SPL_HALT_IDLE;
          end
        end else if (pwr == SPL_RESIDUE && (controller_role_bit || sh_done)) begin
          next_pwr = SPL_RUN;
        end
      end
      SPL_HALT_IDLE: begin
        if (!halt_mode) begin
          next_pwr = SPL_RUN;
        end
      end
      SPL_HALT_ARMED: begin
        if (!halt_mode) begin
          next_pwr = controller_role_bit ? SPL_RUN : SPL_RESIDUE;
        end
      end
      default: next_pwr = SPL_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwr <= SPL_RUN;
    end else begin
      pwr <= next_pwr;
    end
  end

  // ****************
  // Control register
  // ****************
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_port_control <= CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        serial_port_control <= wdata;
        // Enable and role stay low while a fault is pending outside its clear sequence
        if (mode_fault_flag && !fault_armed) begin
          serial_port_control[CB_PE] <= 1'b0;
          serial_port_control[CB_ROLE] <= 1'b0;
        end
      end
      if (fault) begin
        serial_port_control[CB_PE] <= 1'b0;
        serial_port_control[CB_ROLE] <= 1'b0;
      end
    end
  end

  // ****************
  // Status flags, set wins over clear
  // ****************
  always_ff @(posedge clk) begin
    if (rst) begin
      transfer_done_flag <= 1'b0;
      done_armed <= 1'b0;
    end else begin
      if (rd_csr && transfer_done_flag) begin
        done_armed <= 1'b1;
      end else if (clr_done) begin
        done_armed <= 1'b0;
      end
      if (count_done) begin
        transfer_done_flag <= 1'b1;
      end else if (clr_done) begin
        transfer_done_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      overrun_flag <= 1'b0;
      data_buffer_reg <= BYTE_ZERO;
    end else begin
      if (count_done && transfer_done_flag && !clr_done) begin
        overrun_flag <= 1'b1;
      end else if (rd_csr) begin
        overrun_flag <= 1'b0;
      end
      // On overrun the buffer keeps the first byte after the last clear
      if (count_done && !(transfer_done_flag && !clr_done)) begin
        data_buffer_reg <= sh_rx;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_fault_flag <= 1'b0;
      fault_armed <= 1'b0;
    end else begin
      if (fault) begin
        mode_fault_flag <= 1'b1;
      end else if (fault_armed && wr_ctrl) begin
        mode_fault_flag <= 1'b0;
      end
      if (rd_csr && mode_fault_flag) begin
        fault_armed <= 1'b1;
      end else if (wr_ctrl) begin
        fault_armed <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wcol_flag <= 1'b0;
      wcol_armed <= 1'b0;
      out_disable <= 1'b0;
      select_source_choice <= 1'b0;
      internal_select_level <= 1'b0;
    end else begin
      if (wr_data && sh_busy) begin
        wcol_flag <= 1'b1;
      end else if (wcol_armed && rd_data) begin
        wcol_flag <= 1'b0;
      end
      if (rd_csr && wcol_flag) begin
        wcol_armed <= 1'b1;
      end else if (rd_data) begin
        wcol_armed <= 1'b0;
      end
      if (wr_csr) begin
        out_disable <= wdata[2];
        select_source_choice <= wdata[1];
        internal_select_level <= wdata[0];
      end
    end
  end

  // ****************
  // Bus read, interrupt and pins
  // ****************
  always_ff @(posedge clk) begin
    if (rst || !rd) begin
      rdata <= BYTE_ZERO;
    end else begin
      case (addr)
        ADDR_DATA: rdata <= data_buffer_reg;
        ADDR_CTRL: rdata <= serial_port_control;
        ADDR_CSR: rdata <= {transfer_done_flag, wcol_flag, overrun_flag, mode_fault_flag,
                            1'b0, out_disable, select_source_choice, internal_select_level};
        default: rdata <= BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
      halt_wake <= 1'b0;
    end else begin
      irq <= serial_port_control[CB_IE] && !cpu_irq_mask &&
             (transfer_done_flag || mode_fault_flag || overrun_flag);
      halt_wake <= pwr == SPL_HALT_ARMED && transfer_done_flag;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      sck_out <= sh_sck;
      sck_oe <= port_enable_bit && controller_role_bit;
      mosi_out <= sh_sd;
      mosi_oe <= port_enable_bit && controller_role_bit && !out_disable;
      miso_out <= sh_sd;
      miso_oe <= port_enable_bit && !controller_role_bit && !out_disable && !ss_eff_n;
    end
  end

  // ****************
  // Checks
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_halt_entry;
    awake && halt_mode ##1 pwr == SPL_HALT_ARMED;
  endsequence

  a_irq_gating: assert property (irq |-> $past(serial_port_control[CB_IE]) && !$past(cpu_irq_mask))
    else $error("interrupt raised while disabled or masked");
  a_irq_raise: assert property (serial_port_control[CB_IE] && !cpu_irq_mask && overrun_flag |=> irq)
    else $error("overrun did not raise the interrupt");
  a_wake_select: assert property (s_halt_entry |-> $past(!ss_eff_n, 1) && !controller_role_bit)
    else $error("halt wake armed without select low in peripheral role");
  a_wake_cause: assert property (halt_wake |-> $past(transfer_done_flag) && $past(pwr) == SPL_HALT_ARMED)
    else $error("halt wake without a completed transfer");
  a_residue_exit: assert property (pwr == SPL_RESIDUE && controller_role_bit && !halt_mode |=> pwr == SPL_RUN)
    else $error("controller role did not leave halt residue");
  a_fault_effect: assert property (fault |=> mode_fault_flag && !serial_port_control[CB_PE] && !serial_port_control[CB_ROLE])
    else $error("mode fault did not clear enable and role");
  a_overrun_set: assert property (count_done && transfer_done_flag && !clr_done |=> overrun_flag)
    else $error("second completion did not set overrun");
  a_done_flag: assert property (count_done |=> transfer_done_flag)
    else $error("completed transfer did not set its flag");
  a_halt_frozen: assert property (pwr == SPL_HALT_IDLE |=> $stable(serial_port_control))
    else $error("control register changed in halt");
  a_periph_no_clock: assert property (!controller_role_bit |=> !div_tick)
    else $error("divider ticks in peripheral role");

endmodule
`default_nettype wire

// ### verif/spl_peer_ctrl.sv
// Remote serial controller model that clocks bytes into the port
`timescale 1ns/10ps
`default_nettype none
module spl_peer_ctrl (
  input wire logic clk,
  output logic sck,
  output logic sd,
  output logic ss_n
);
  logic idle_level_select = 1'b0;
  logic capture_edge_select = 1'b0;
  initial begin
    sck = 1'b0;
    sd = 1'b0;
    ss_n = 1'b1;
  end
  // Same polarity and phase as the port; clock parks at its idle level
  task automatic cfg(input logic pol, input logic pha);
    @(posedge clk);
    idle_level_select = pol;
    capture_edge_select = pha;
    sck <= pol;
  endtask
  // A released data line flips so a stale level is never read as valid
  task automatic select(input logic lvl);
    @(posedge clk);
    ss_n <= lvl;
    if (lvl) sd <= ~sd;
    repeat (4) @(posedge clk);
  endtask
  // One byte, MSB first, four CPU cycles per clock half
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    sck <= idle_level_select;
    if (!capture_edge_select) sd <= b[7];
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      sck <= ~idle_level_select;
      if (capture_edge_select) sd <= b[i];
      repeat (4) @(posedge clk);
      sck <= idle_level_select;
      if (!capture_edge_select && i > 0) sd <= b[i-1];
    end
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the serial port control block
`timescale 1ns/10ps
`default_nettype none
module testbench
  import spl_pkg::*;
;
  localparam logic [17:0] RATE_CODES = 18'b100000001110010011;
  logic clk;
  logic rst;
  logic wr;
  logic rd;
  logic cpu_irq_mask;
  logic halt_mode;
  logic irq;
  logic halt_wake;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic sck_in;
  logic sd_line;
  logic ss_n_in;
  logic sck_out;
  logic sck_oe;
  logic mosi_out;
  logic mosi_oe;
  logic miso_out;
  logic miso_oe;
  int fails = 0;
  int checks = 0;

  spl_lowpower_irq_control u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode), .irq(irq),
    .halt_wake(halt_wake), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(sd_line), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(sd_line),
    .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in));
  spl_peer_ctrl u_peer (.clk(clk), .sck(sck_in), .sd(sd_line), .ss_n(ss_n_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************
  // Shared tasks
  // ****************
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return irq;
      1: return sck_out;
      default: return halt_wake;
    endcase
  endfunction
  task automatic wait_for(input int k, input logic lvl, input int bound, output int n);
    n = 0;
    while (pick(k) !== lvl) begin
      @(posedge clk);
      #1;
      n++;
      if (n > bound) begin
        fails++;
        $display("BAD t=%0t got %h exp %h", $time, pick(k), lvl);
        give_verdict();
      end
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    logic [7:0] d;
    rd_reg(ADDR_CTRL, d);
    chk(d, CTRL_RST);
    rd_reg(8'h30, d);
    chk(d, 8'h00);
    wr_reg(ADDR_CTRL, 8'h2f);
    rd_reg(ADDR_CTRL, d);
    chk(d, 8'h2f);
    wr_reg(ADDR_CTRL, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_rates();
    logic [7:0] d;
    logic [2:0] c;
    logic pol;
    int n;
    int h;
    for (int i = 0; i < 6; i++) begin
      c = RATE_CODES[17 - 3 * i -: 3];
      pol = i[0];
      wr_reg(ADDR_CTRL, 8'h00);
      wr_reg(ADDR_CTRL, {2'b11, c[2], 1'b1, pol, 1'b0, c[1:0]});
      repeat (2) @(posedge clk);
      #1 chk({5'h0, sck_oe, mosi_oe, miso_oe}, 8'h06);
      chk({7'h0, sck_out}, {7'h0, pol});
      wr_reg(ADDR_DATA, 8'ha5);
      wait_for(1, ~pol, 200, n);
      chk({7'h0, mosi_out}, 8'h01);
      wait_for(1, pol, 200, h);
      chk(h[7:0], 8'h02 << i);
      wait_for(0, 1'b1, 1200, n);
      chk({7'h0, sck_out}, {7'h0, pol});
      rd_reg(ADDR_CSR, d);
      chk(d, 8'h80);
      rd_reg(ADDR_DATA, d);
      chk(d, 8'h00);
    end
    wr_reg(ADDR_CTRL, 8'h00);
    $display("test rates done");
  endtask
  task automatic t_periph();
    logic [7:0] d;
    int n;
    for (int p = 0; p < 2; p++) begin
      wr_reg(ADDR_CTRL, 8'h00);
      u_peer.cfg(p[0], p[0]);
      wr_reg(ADDR_CTRL, {4'hc, p[0], p[0], 2'b11});
      cpu_irq_mask <= 1'b1;
      u_peer.select(1'b0);
      wr_reg(ADDR_DATA, 8'h96 ^ {8{p[0]}});
      @(posedge clk);
      #1 chk({6'h0, miso_oe, miso_out}, {6'h0, 1'b1, ~p[0]});
      u_peer.send(8'h96 ^ {8{p[0]}});
      u_peer.select(1'b1);
      chk({7'h0, irq}, 8'h00);
      cpu_irq_mask <= 1'b0;
      wait_for(0, 1'b1, 3, n);
      rd_reg(ADDR_CSR, d);
      chk(d, 8'h80);
      rd_reg(ADDR_DATA, d);
      chk(d, 8'h96 ^ {8{p[0]}});
    end
    u_peer.select(1'b0);
    u_peer.send(8'h3c);
    u_peer.send(8'hc3);
    u_peer.select(1'b1);
    rd_reg(ADDR_CSR, d);
    chk(d, 8'ha0);
    rd_reg(ADDR_DATA, d);
    chk(d, 8'h3c);
    wait_for(0, 1'b0, 3, n);
    wr_reg(ADDR_CTRL, 8'h00);
    $display("test peripheral done");
  endtask
  task automatic t_fault();
    logic [7:0] d;
    int n;
    u_peer.cfg(1'b0, 1'b0);
    u_peer.select(1'b0);
    wr_reg(ADDR_CTRL, 8'hd0);
    wait_for(0, 1'b1, 4, n);
    rd_reg(ADDR_CTRL, d);
    chk(d, 8'h80);
    rd_reg(ADDR_CSR, d);
    chk(d, 8'h10);
    u_peer.select(1'b1);
    wr_reg(ADDR_CTRL, 8'h00);
    rd_reg(ADDR_CSR, d);
    chk(d, 8'h00);
    $display("test fault done");
  endtask
  task automatic t_halt();
    logic [7:0] d;
    int n;
    wr_reg(ADDR_CTRL, 8'h40);
    u_peer.select(1'b0);
    halt_mode <= 1'b1;
    repeat (2) @(posedge clk);
    wr_reg(ADDR_CTRL, 8'hff);
    u_peer.send(8'ha5);
    wait_for(2, 1'b1, 4, n);
    u_peer.send(8'h5a);
    halt_mode <= 1'b0;
    rd_reg(ADDR_CTRL, d);
    chk(d, 8'h40);
    rd_reg(ADDR_CSR, d);
    chk(d, 8'ha0);
    rd_reg(ADDR_DATA, d);
    chk(d, 8'ha5);
    u_peer.send(8'h77);
    u_peer.send(8'h81);
    rd_reg(ADDR_CSR, d);
    chk(d, 8'h80);
    rd_reg(ADDR_DATA, d);
    chk(d, 8'h81);
    halt_mode <= 1'b1;
    u_peer.send(8'h42);
    wait_for(2, 1'b1, 4, n);
    @(posedge clk);
    halt_mode <= 1'b0;
    u_peer.select(1'b1);
    wr_reg(ADDR_CTRL, 8'hd0);
    rd_reg(ADDR_CSR, d);
    rd_reg(ADDR_DATA, d);
    wr_reg(ADDR_DATA, 8'h11);
    wait_for(0, 1'b1, 200, n);
    wr_reg(ADDR_CTRL, 8'h00);
    $display("test halt done");
  endtask
  task automatic t_nowake();
    wr_reg(ADDR_CTRL, 8'h40);
    halt_mode <= 1'b1;
    repeat (2) @(posedge clk);
    u_peer.select(1'b0);
    u_peer.send(8'he7);
    chk({7'h0, halt_wake}, 8'h00);
    halt_mode <= 1'b0;
    u_peer.select(1'b1);
    $display("test no wake done");
  endtask

  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    cpu_irq_mask = 1'b0;
    halt_mode = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rates();
    t_periph();
    t_fault();
    t_halt();
    t_nowake();
    give_verdict();
  end
endmodule
`default_nettype wire
